// File: verilog/wdog_pkg.sv
/*
 * Shared constants for the watchdog fail-safe supervisor.
 * Assumes a single 20 MHz system clock and no software register map.
 */
package wdog_pkg;

   localparam int unsigned CLK_HZ          = 20_000_000;
   // Default watchdog timeout in microseconds
   localparam int unsigned WD_TIMEOUT_US   = 10_000;
   localparam int unsigned WD_TIMEOUT_CYC  =
      (CLK_HZ / 1_000_000) * WD_TIMEOUT_US;
   localparam int unsigned NUM_CHANNELS    = 12;
   localparam int unsigned FAULT_W         = 12;
   localparam int unsigned FAULT_MSB       = 11;
   // Channel positions of the fail-safe high-side outputs
   localparam int unsigned HS_CH_0         = 0;
   localparam int unsigned HS_CH_2         = 2;
   localparam logic        SYNC_RESET_VAL  = 1'b0;

   typedef enum logic [1:0] {
      ST_STANDBY  = 2'b00,
      ST_NORMAL   = 2'b01,
      ST_FAILSAFE = 2'b10
   } wd_state_t;

endpackage

// File: verilog/sync2.sv
/*
 * Two-flop synchroniser for single-bit levels entering the clk_sys domain.
 * Assumes the input is a plain level; no pulse shorter than two clocks.
 */
`timescale 1ns/1ns
module sync2 #(
   parameter logic RESET_VAL = 1'b0
) (
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic d,
   output logic      q
);

   typedef struct packed {
      logic meta;
      logic q;
   } sync_state_t;

   sync_state_t s_r;
   sync_state_t s_nxt;

   always_comb begin
      s_nxt.meta = d;
      s_nxt.q    = s_r.meta;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '{meta: RESET_VAL, q: RESET_VAL};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign q = s_r.q;

endmodule

// File: verilog/watchdog_failsafe_supervisor.sv
/*
 * Watchdog fail-safe supervisor: watches the host toggle, forces the
 * fail-safe high-side outputs on timeout, flags faults and shifts the
 * per-channel fault word out on the serial port.
 * Assumes all pin inputs are asynchronous to clk_sys and that the serial
 * clock is much slower than clk_sys, so it is sampled as a level.
 * The open-drain flag and the serial data pin are driven through their
 * enables; the pads themselves sit outside this block.
 */
// Summary of operation
// - Reset low clears fault state and holds standby.
// - Reset release starts a fresh watchdog timeout interval.
// - No toggle within the timeout sends the block to fail-safe.
// - Fail-safe with select high turns on high-side outputs 0 and 2.
// - Select low disables the watchdog and the fail-safe behaviour.
// - Any fault pulls the open-drain fault flag low.
// - Watchdog timing runs only while wake is high.
// - Fail-safe outputs hold until reinit or select low, then normal operation resumes.
// - When selected, serial output sends fault bits 11 to 0, MSB first.
`timescale 1ns/1ns
module watchdog_failsafe_supervisor
   import wdog_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYCLES = WD_TIMEOUT_CYC
) (
   input  wire logic                clk_sys,
   input  wire logic                rst_n,
   input  wire logic                watchdog_toggle_in,
   input  wire logic                failsafe_select_in,
   input  wire logic                wake_in,
   input  wire logic [FAULT_W-1:0]  channel_fault_in,
   input  wire logic                spi_cs_n,
   input  wire logic                spi_sclk,
   output logic                     spi_sdo,
   output logic                     spi_sdo_oe,
   output logic                     fault_flag_n_o,
   output logic                     fault_flag_n_oe,
   output logic                     high_side_out_0,
   output logic                     high_side_out_2,
   output logic                     standby_o
);

   // One count of headroom so the full interval fits the counter
   localparam int unsigned CNT_W = $clog2(TIMEOUT_CYCLES + 1);

   // The down-counter needs a reload and a last cycle to time anything
   if (TIMEOUT_CYCLES < 2) begin : g_bad_timeout
      $error("TIMEOUT_CYCLES must be at least 2");
   end

   // Reset release through two flops; assertion stays asynchronous
   // A raw pin release could free the flops on different edges
   logic [1:0] rst_sync_r;
   logic       rst_l;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_l = rst_sync_r[1];

   // Reset values follow each pin's idle level, so no false edge is seen
   // when the block comes out of reset
   logic wd_s;
   logic fsi_s;
   logic wake_s;
   logic cs_n_s;
   logic sclk_s;

   sync2 #(.RESET_VAL(1'b0)) u_sync_wd (
      .clk_sys (clk_sys),
      .rst_n   (rst_l),
      .d       (watchdog_toggle_in),
      .q       (wd_s)
   );
   sync2 #(.RESET_VAL(1'b1)) u_sync_fsi (
      .clk_sys (clk_sys),
      .rst_n   (rst_l),
      .d       (failsafe_select_in),
      .q       (fsi_s)
   );
   sync2 #(.RESET_VAL(1'b0)) u_sync_wake (
      .clk_sys (clk_sys),
      .rst_n   (rst_l),
      .d       (wake_in),
      .q       (wake_s)
   );
   sync2 #(.RESET_VAL(1'b1)) u_sync_cs (
      .clk_sys (clk_sys),
      .rst_n   (rst_l),
      .d       (spi_cs_n),
      .q       (cs_n_s)
   );
   sync2 #(.RESET_VAL(1'b0)) u_sync_sclk (
      .clk_sys (clk_sys),
      .rst_n   (rst_l),
      .d       (spi_sclk),
      .q       (sclk_s)
   );

   // Fault inputs are a bus of levels; each bit gets its own two flops
   logic [FAULT_W-1:0] fault_s;

   for (genvar i = 0; i < FAULT_W; i++) begin : g_fsync
      sync2 #(.RESET_VAL(1'b0)) u_sync_flt (
         .clk_sys (clk_sys),
         .rst_n   (rst_l),
         .d       (channel_fault_in[i]),
         .q       (fault_s[i])
      );
   end

   // All supervisor state lives in one record: the comb block builds the
   // next copy and a single flop stage holds it
   typedef struct packed {
      wd_state_t          state;
      logic [CNT_W-1:0]   cnt;
      logic               wd_prev;
      logic               sclk_prev;
      logic [FAULT_W-1:0] fault_lat;
      logic [FAULT_W-1:0] shift;
      logic               sdo;
      logic               sel;
      logic               hs_on;
   } sup_state_t;

   sup_state_t s_r;
   sup_state_t s_nxt;

   logic wd_edge;
   logic wd_armed;
   logic sclk_rise;

   assign wd_edge   = wd_s ^ s_r.wd_prev;
   // Select or wake low parks the count at full: no toggling needed
   assign wd_armed  = fsi_s && wake_s;
   assign sclk_rise = sclk_s && !s_r.sclk_prev;

   always_comb begin
      s_nxt           = s_r;
      s_nxt.wd_prev   = wd_s;
      s_nxt.sclk_prev = sclk_s;
      // Faults are sticky until reinitialised; a new one is never lost
      s_nxt.fault_lat = s_r.fault_lat | fault_s;

      unique case (s_r.state)
         ST_STANDBY: begin
            // First cycle after release: start a full interval
            s_nxt.cnt   = CNT_W'(TIMEOUT_CYCLES);
            s_nxt.state = ST_NORMAL;
         end
         ST_NORMAL: begin
            // Count down; a last cycle without a toggle trips fail-safe
            if (!wd_armed || wd_edge) begin
               s_nxt.cnt = CNT_W'(TIMEOUT_CYCLES);
            end else if (s_r.cnt <= CNT_W'(1)) begin
               s_nxt.cnt   = '0;
               s_nxt.state = ST_FAILSAFE;
            end else begin
               s_nxt.cnt = s_r.cnt - CNT_W'(1);
            end
         end
         ST_FAILSAFE: begin
            // Held until reset or select low; select low returns to normal with a full interval,
            // because a grounded select disables fail-safe outright
            if (!fsi_s) begin
               s_nxt.state = ST_NORMAL;
               s_nxt.cnt   = CNT_W'(TIMEOUT_CYCLES);
            end
         end
         default: begin
            s_nxt.state = ST_STANDBY;
         end
      endcase

      // Serial fault readout, shifted on serial clock rising edges
      // The word is reloaded while deselected, so a frame shows the
      // faults latched up to the select; later ones wait for the next
      s_nxt.sel = !cs_n_s;
      if (cs_n_s) begin
         s_nxt.shift = s_r.fault_lat;
         s_nxt.sdo   = s_r.fault_lat[FAULT_MSB];
      end else if (!s_r.sel) begin
         s_nxt.shift = s_r.fault_lat;
         s_nxt.sdo   = s_r.fault_lat[FAULT_MSB];
      end else if (sclk_rise) begin
         s_nxt.shift = {s_r.shift[FAULT_W-2:0], 1'b0};
         s_nxt.sdo   = s_r.shift[FAULT_MSB-1];
      end

      // Registered so the high-side drivers never see a decode glitch
      s_nxt.hs_on = (s_nxt.state == ST_FAILSAFE) && fsi_s;
   end

   always_ff @(posedge clk_sys or negedge rst_l) begin
      if (!rst_l) begin
         s_r <= '{state:     ST_STANDBY,
                  cnt:       '0,
                  wd_prev:   1'b0,
                  sclk_prev: 1'b0,
                  fault_lat: '0,
                  shift:     '0,
                  sdo:       1'b0,
                  sel:       1'b0,
                  hs_on:     1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign high_side_out_0 = s_r.hs_on;
   assign high_side_out_2 = s_r.hs_on;
   assign spi_sdo         = s_r.sdo;
   assign spi_sdo_oe      = s_r.sel;
   // Open drain: the pad level is fixed low, only the enable moves
   assign fault_flag_n_o  = 1'b0;
   assign fault_flag_n_oe = |s_r.fault_lat;
   assign standby_o       = (s_r.state == ST_STANDBY);

endmodule

// File: verification/wdog_chk.sv
/* Port checker for the watchdog supervisor, bound to its top module.
   Assumes TIMEOUT_CYCLES is handed on from the bound instance. */
`timescale 1ns/1ns
module wdog_chk #(
   parameter int unsigned TIMEOUT_CYCLES = 20
) (
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic        watchdog_toggle_in,
   input wire logic        failsafe_select_in,
   input wire logic        wake_in,
   input wire logic [11:0] channel_fault_in,
   input wire logic        spi_cs_n,
   input wire logic        spi_sdo_oe,
   input wire logic        fault_flag_n_o,
   input wire logic        fault_flag_n_oe,
   input wire logic        high_side_out_0,
   input wire logic        high_side_out_2,
   input wire logic        standby_o
);
   logic [15:0] idle_r;
   // Idle time of the enabled watchdog; saturates so it never wraps
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)
         idle_r <= '0;
      else if ($changed(watchdog_toggle_in) || !wake_in || !failsafe_select_in)
         idle_r <= '0;
      else if (~&idle_r)
         idle_r <= idle_r + 16'h0001;
   end
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   sequence s_sel_hold;
      failsafe_select_in [*4] ##0 high_side_out_0;
   endsequence
   property p_standby;
      $rose(rst_n) |-> standby_o && !high_side_out_0 && !fault_flag_n_oe;
   endproperty
   a_standby: assert property (p_standby) else $error("not cleared");
   property p_late;
      idle_r == 16'(TIMEOUT_CYCLES + 8) |-> high_side_out_0;
   endproperty
   a_late: assert property (p_late) else $error("no fail-safe");
   property p_early;
      $rose(high_side_out_0) |-> idle_r >= 16'(TIMEOUT_CYCLES);
   endproperty
   a_early: assert property (p_early) else $error("early timeout");
   property p_pair;
      high_side_out_0 == high_side_out_2 &&
         (!$rose(high_side_out_0) || $past(failsafe_select_in, 3));
   endproperty
   a_pair: assert property (p_pair) else $error("outputs differ");
   property p_sel_off;
      !failsafe_select_in [*6] |=> !high_side_out_0;
   endproperty
   a_sel_off: assert property (p_sel_off) else $error("select ignored");
   property p_wake_off;
      !wake_in [*6] |-> !$rose(high_side_out_0);
   endproperty
   a_wake_off: assert property (p_wake_off) else $error("wake ignored");
   property p_hold;
      s_sel_hold |=> high_side_out_0;
   endproperty
   a_hold: assert property (p_hold) else $error("fail-safe dropped");
   property p_flag;
      $rose(|channel_fault_in) |-> ##[1:4] fault_flag_n_oe;
   endproperty
   a_flag: assert property (p_flag) else $error("flag late");
   property p_flag_low;
      fault_flag_n_oe |=> fault_flag_n_oe && !fault_flag_n_o;
   endproperty
   a_flag_low: assert property (p_flag_low) else $error("flag lost");
   property p_sel_oe;
      $fell(spi_cs_n) |-> ##[1:4] spi_sdo_oe;
   endproperty
   a_sel_oe: assert property (p_sel_oe) else $error("no drive");
endmodule
bind watchdog_failsafe_supervisor wdog_chk #(
   .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) chk (.clk_sys, .rst_n, .watchdog_toggle_in, .failsafe_select_in,
   .wake_in, .channel_fault_in, .spi_cs_n, .spi_sdo_oe, .fault_flag_n_o,
   .fault_flag_n_oe, .high_side_out_0, .high_side_out_2, .standby_o);

// File: verification/host_kicker.sv
/* Host model: kicks the watchdog toggle at a steady pace.
   Assumes the bench keeps run low through reset. */
`timescale 1ns/1ns
module host_kicker #(
   parameter int PERIOD = 8
) (
   input  wire logic clk_sys,
   input  wire logic run,
   output logic      watchdog_toggle_in
);
   int n = 0;
   initial watchdog_toggle_in = 1'b0;
   // Well inside the timeout, so only a stopped host trips it
   always @(posedge clk_sys) begin
      n = (run && n < PERIOD - 1) ? n + 1 : 0;
      if (run && n == 0)
         watchdog_toggle_in <= #2 ~watchdog_toggle_in;
   end
endmodule

// File: verification/watchdog_failsafe_supervisor_test.sv
/* Self-checking bench for the watchdog supervisor.
   Assumes the checker and host model files are compiled first. */
`timescale 1ns/1ns
module watchdog_failsafe_supervisor_test;
   import wdog_pkg::*;
   localparam int unsigned TMO = 20;
   logic clk_sys = 1'b0, rst_n = 1'b0, run = 1'b0, wake_in = 1'b1;
   logic failsafe_select_in = 1'b1, spi_cs_n = 1'b1, spi_sclk = 1'b0;
   logic [FAULT_W-1:0] channel_fault_in = '0;
   logic watchdog_toggle_in, spi_sdo, spi_sdo_oe, fault_flag_n_o;
   logic fault_flag_n_oe, high_side_out_0, high_side_out_2, standby_o;
   int failures = 0, cmp_count = 0;
   always #25 clk_sys = ~clk_sys;
   host_kicker host (.clk_sys, .run, .watchdog_toggle_in);
   watchdog_failsafe_supervisor #(.TIMEOUT_CYCLES(TMO)) dut (.clk_sys,
      .rst_n, .watchdog_toggle_in, .failsafe_select_in, .wake_in,
      .channel_fault_in, .spi_cs_n, .spi_sclk, .spi_sdo, .spi_sdo_oe,
      .fault_flag_n_o, .fault_flag_n_oe, .high_side_out_0,
      .high_side_out_2, .standby_o);
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask
   task automatic chk(input logic [11:0] got, exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic wait_hs;
      int i;
      for (i = 0; i < 40 && high_side_out_0 !== 1'b1; i++) cyc(1);
      if (i == 40) begin
         failures++;
         $display("BAD %0t fail-safe outputs never rose", $time);
         report_and_stop;
      end
   endtask
   task automatic t_reset;
      rst_n = 1'b0;
      run = 1'b0;
      cyc(3);
      chk(standby_o, 1'b1, "standby");
      chk(high_side_out_0, 1'b0, "hs in reset");
      chk(fault_flag_n_oe, 1'b0, "flag in reset");
      rst_n = 1'b1;
      run = 1'b1;
      cyc(6);
      chk(standby_o, 1'b0, "awake");
      $display("t_reset done");
   endtask
   task automatic t_serial;
      logic [11:0] w;
      w = 12'ha53;
      channel_fault_in = w;
      cyc(5);
      channel_fault_in = '0;
      chk(fault_flag_n_oe, 1'b1, "flag");
      chk(fault_flag_n_o, 1'b0, "flag level");
      spi_cs_n = 1'b0;
      cyc(5);
      chk(spi_sdo_oe, 1'b1, "selected");
      for (int b = 11; b >= 0; b--) begin
         chk(spi_sdo, w[b], "serial bit");
         spi_sclk = 1'b1;
         cyc(4);
         spi_sclk = 1'b0;
         cyc(4);
      end
      spi_cs_n = 1'b1;
      cyc(5);
      chk(spi_sdo_oe, 1'b0, "released");
      $display("t_serial done");
   endtask
   task automatic t_watchdog;
      cyc(3 * TMO);
      chk(high_side_out_0, 1'b0, "kicked");
      run = 1'b0;
      wait_hs;
      chk(high_side_out_2, 1'b1, "hs2 on");
      cyc(2 * TMO);
      chk(high_side_out_0, 1'b1, "hs held");
      failsafe_select_in = 1'b0;
      cyc(2 * TMO);
      chk(high_side_out_0, 1'b0, "select off");
      failsafe_select_in = 1'b1;
      wake_in = 1'b0;
      cyc(2 * TMO);
      chk(high_side_out_0, 1'b0, "wake off");
      wake_in = 1'b1;
      wait_hs;
      $display("t_watchdog done");
   endtask
   initial begin
      t_reset;
      t_serial;
      t_watchdog;
      t_reset;
      report_and_stop;
   end
endmodule
